/* File: rtl/lbc_pkg.sv */
package lbc_pkg;
    localparam int LBC_NUM_REGS = 13;
    // Subaddresses
    localparam logic [7:0] LBC_SUB_MAIN_BRIGHT = 8'h51;
    localparam logic [7:0] LBC_SUB_SIDE_BRIGHT = 8'h55;
    localparam logic [7:0] LBC_SUB_EXP_TILT    = 8'h59;
    localparam logic [7:0] LBC_SUB_EXP_THR     = 8'h5d;
    localparam logic [7:0] LBC_SUB_MAIN_CONT   = 8'h61;
    localparam logic [7:0] LBC_SUB_SIDE_CONT   = 8'h65;
    localparam logic [7:0] LBC_SUB_PK_GAIN     = 8'h69;
    localparam logic [7:0] LBC_SUB_PK_CORING   = 8'h6d;
    localparam logic [7:0] LBC_SUB_EXT_RGB     = 8'h71;
    localparam logic [7:0] LBC_SUB_EXP_WIN     = 8'h73;
    localparam logic [7:0] LBC_SUB_PIC_SET     = 8'h75;
    localparam logic [7:0] LBC_SUB_TRANS       = 8'h79;
    localparam logic [7:0] LBC_SUB_EXP_DIS     = 8'h7d;
    // Register array indices
    localparam logic [3:0] LBC_IDX_MAIN_BRIGHT = 4'h0;
    localparam logic [3:0] LBC_IDX_SIDE_BRIGHT = 4'h1;
    localparam logic [3:0] LBC_IDX_EXP_TILT    = 4'h2;
    localparam logic [3:0] LBC_IDX_EXP_THR     = 4'h3;
    localparam logic [3:0] LBC_IDX_MAIN_CONT   = 4'h4;
    localparam logic [3:0] LBC_IDX_SIDE_CONT   = 4'h5;
    localparam logic [3:0] LBC_IDX_PK_GAIN     = 4'h6;
    localparam logic [3:0] LBC_IDX_PK_CORING   = 4'h7;
    localparam logic [3:0] LBC_IDX_EXT_RGB     = 4'h8;
    localparam logic [3:0] LBC_IDX_EXP_WIN     = 4'h9;
    localparam logic [3:0] LBC_IDX_PIC_SET     = 4'ha;
    localparam logic [3:0] LBC_IDX_TRANS       = 4'hb;
    localparam logic [3:0] LBC_IDX_EXP_DIS     = 4'hc;
    localparam logic [3:0] LBC_IDX_NONE        = 4'hf;
    // Field positions
    localparam int LBC_CONT_MSB    = 5;
    localparam int LBC_TILT_MSB    = 3;
    localparam int LBC_AMOUNT_LSB  = 4;
    localparam int LBC_AMOUNT_MSB  = 8;
    localparam int LBC_UNDER_MSB   = 3;
    localparam int LBC_OVER_LSB    = 4;
    localparam int LBC_OVER_MSB    = 7;
    localparam int LBC_INVERT_BIT  = 8;
    localparam int LBC_CORING_MSB  = 4;
    localparam int LBC_FREQ_BIT    = 8;
    localparam int LBC_WL_BIT      = 0;
    localparam int LBC_HSTART_LSB  = 1;
    localparam int LBC_HSTART_MSB  = 8;
    localparam int LBC_MASK_MSB    = 7;
    // Values after reset and fixed figures
    localparam logic [8:0] LBC_REG_RST    = 9'h000;
    localparam logic [8:0] LBC_STOP_50HZ  = 9'h150;
    localparam logic [8:0] LBC_STOP_60HZ  = 9'h11b;
    localparam logic [5:0] LBC_PK_UNITY   = 6'h08;
    localparam logic [6:0] LBC_CHIP_ADDR  = 7'h45;
    localparam logic [3:0] LBC_BITS_BYTE  = 4'h8;

    typedef enum logic [2:0] {
        LBC_ST_IDLE, LBC_ST_ADDR, LBC_ST_SUB, LBC_ST_HI, LBC_ST_LO, LBC_ST_ACK, LBC_ST_SKIP
    } lbc_i2c_state_type;
endpackage

/* File: rtl/lbc_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module lbc_regs
    import lbc_pkg::*;
#(
    parameter logic [6:0] CHIP_ADDR = LBC_CHIP_ADDR,
    parameter int         PRIO_W    = 3
) (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                srst,
    // I2C pins
    input  wire logic                scl_in,
    input  wire logic                sda_in,
    output logic                     sda_out,
    output logic                     sda_oe_n,
    // Video timing and priority
    input  wire logic                vsync,
    input  wire logic [PRIO_W-1:0]   signal_priority,
    // Latched register fields
    output logic [5:0]               main_contrast_gain,
    output logic [5:0]               side_contrast_gain,
    output logic [8:0]               main_brightness_offset,
    output logic [8:0]               side_brightness_offset,
    output logic [7:0]               picture_set_select_mask,
    output logic [7:0]               external_rgb_select_mask,
    output logic [3:0]               expander_tilt,
    output logic [4:0]               expander_amount,
    output logic [8:0]               expander_threshold,
    output logic                     window_length_select,
    output logic [7:0]               half_start_line,
    output logic [7:0]               expander_disable_mask,
    output logic [3:0]               undershoot_level,
    output logic [3:0]               overshoot_level,
    output logic                     peaking_invert,
    output logic [4:0]               coring_level,
    output logic                     center_frequency_select,
    output logic [7:0]               transient_suppress_mask,
    // Values for the current priority, and derived window and peaking values
    output logic [5:0]               contrast_gain,
    output logic [8:0]               brightness_offset,
    output logic                     use_side_set,
    output logic                     use_external_rgb,
    output logic                     expander_active,
    output logic                     transient_suppress_active,
    output logic [8:0]               window_start_line,
    output logic [8:0]               window_stop_line,
    output logic [5:0]               peaking_gain_eighths
);
    if (PRIO_W < 1 || PRIO_W > 3) begin : g_chk
        $error("PRIO_W must be 1 to 3");
    end

    logic              scl_m, scl_s, scl_d;
    logic              sda_m, sda_s, sda_d;
    logic              scl_rise, scl_fall, i2c_start, i2c_stop;
    lbc_i2c_state_type state, after_ack;
    logic [3:0]        bit_cnt;
    logic [7:0]        shreg;
    logic [7:0]        sub_addr;
    logic              data_b8;
    logic              wr_commit;
    logic [8:0]        wr_data;
    logic [8:0]        shadow [LBC_NUM_REGS];
    logic [8:0]        act    [LBC_NUM_REGS];
    logic              vsync_d, vs_edge;

    function automatic logic [3:0] lbc_index(input logic [7:0] sub);
        unique case (sub)
            LBC_SUB_MAIN_BRIGHT: lbc_index = LBC_IDX_MAIN_BRIGHT;
            LBC_SUB_SIDE_BRIGHT: lbc_index = LBC_IDX_SIDE_BRIGHT;
            LBC_SUB_EXP_TILT:    lbc_index = LBC_IDX_EXP_TILT;
            LBC_SUB_EXP_THR:     lbc_index = LBC_IDX_EXP_THR;
            LBC_SUB_MAIN_CONT:   lbc_index = LBC_IDX_MAIN_CONT;
            LBC_SUB_SIDE_CONT:   lbc_index = LBC_IDX_SIDE_CONT;
            LBC_SUB_PK_GAIN:     lbc_index = LBC_IDX_PK_GAIN;
            LBC_SUB_PK_CORING:   lbc_index = LBC_IDX_PK_CORING;
            LBC_SUB_EXT_RGB:     lbc_index = LBC_IDX_EXT_RGB;
            LBC_SUB_EXP_WIN:     lbc_index = LBC_IDX_EXP_WIN;
            LBC_SUB_PIC_SET:     lbc_index = LBC_IDX_PIC_SET;
            LBC_SUB_TRANS:       lbc_index = LBC_IDX_TRANS;
            LBC_SUB_EXP_DIS:     lbc_index = LBC_IDX_EXP_DIS;
            default:             lbc_index = LBC_IDX_NONE;
        endcase
    endfunction

    // Pin synchronisers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            {scl_m, scl_s, scl_d} <= 3'h7;
            {sda_m, sda_s, sda_d} <= 3'h7;
        end else begin
            {scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
            {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
        end
    end

    assign scl_rise  = scl_s & ~scl_d;
    assign scl_fall  = ~scl_s & scl_d;
    assign i2c_start = scl_s & scl_d & sda_d & ~sda_s;
    assign i2c_stop  = scl_s & scl_d & ~sda_d & sda_s;

    // I2C slave, write-only
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state     <= LBC_ST_IDLE;
            after_ack <= LBC_ST_IDLE;
            bit_cnt   <= 4'h0;
            shreg     <= 8'h00;
            sub_addr  <= 8'h00;
            data_b8   <= 1'b0;
            sda_oe_n  <= 1'b1;
            wr_commit <= 1'b0;
        end else begin
            wr_commit <= 1'b0;
            if (i2c_start) begin
                state    <= LBC_ST_ADDR;
                bit_cnt  <= 4'h0;
                sda_oe_n <= 1'b1;
            end else if (i2c_stop) begin
                state    <= LBC_ST_IDLE;
                sda_oe_n <= 1'b1;
            end else begin
                unique case (state)
                    LBC_ST_IDLE, LBC_ST_SKIP: begin
                        sda_oe_n <= 1'b1;
                    end
                    LBC_ST_ACK: begin
                        if (scl_fall) begin
                            sda_oe_n <= 1'b1;
                            state    <= after_ack;
                        end
                    end
                    LBC_ST_ADDR, LBC_ST_SUB, LBC_ST_HI, LBC_ST_LO: begin
                        if (scl_rise && bit_cnt != LBC_BITS_BYTE) begin
                            shreg   <= {shreg[6:0], sda_s};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == LBC_BITS_BYTE) begin
                            bit_cnt <= 4'h0;
                            if (state == LBC_ST_ADDR) begin
                                if (shreg[7:1] == CHIP_ADDR && !shreg[0]) begin
                                    sda_oe_n  <= 1'b0;
                                    state     <= LBC_ST_ACK;
                                    after_ack <= LBC_ST_SUB;
                                end else begin
                                    state <= LBC_ST_SKIP;
                                end
                            end else begin
                                sda_oe_n <= 1'b0;
                                state    <= LBC_ST_ACK;
                                if (state == LBC_ST_SUB) begin
                                    sub_addr  <= shreg;
                                    after_ack <= LBC_ST_HI;
                                end else if (state == LBC_ST_HI) begin
                                    data_b8   <= shreg[0];
                                    after_ack <= LBC_ST_LO;
                                end else begin
                                    wr_commit <= 1'b1;
                                    after_ack <= LBC_ST_HI;
                                end
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Open-drain data value
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    assign wr_data = {data_b8, shreg};

    // Shadow registers written from the bus
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int i = 0; i < LBC_NUM_REGS; i++) begin
                shadow[i] <= LBC_REG_RST;
            end
        end else if (wr_commit && lbc_index(sub_addr) != LBC_IDX_NONE) begin
            shadow[lbc_index(sub_addr)] <= wr_data;
        end
    end

    // Transfer to active set at vertical sync
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            vsync_d <= 1'b0;
        end else begin
            vsync_d <= vsync;
        end
    end

    assign vs_edge = vsync & ~vsync_d;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int i = 0; i < LBC_NUM_REGS; i++) begin
                act[i] <= LBC_REG_RST;
            end
        end else if (vs_edge) begin
            for (int i = 0; i < LBC_NUM_REGS; i++) begin
                act[i] <= shadow[i];
            end
        end
    end

    // Field views of the active set
    assign main_contrast_gain       = act[LBC_IDX_MAIN_CONT][LBC_CONT_MSB:0];
    assign side_contrast_gain       = act[LBC_IDX_SIDE_CONT][LBC_CONT_MSB:0];
    assign main_brightness_offset   = act[LBC_IDX_MAIN_BRIGHT];
    assign side_brightness_offset   = act[LBC_IDX_SIDE_BRIGHT];
    assign picture_set_select_mask  = act[LBC_IDX_PIC_SET][LBC_MASK_MSB:0];
    assign external_rgb_select_mask = act[LBC_IDX_EXT_RGB][LBC_MASK_MSB:0];
    assign expander_tilt            = act[LBC_IDX_EXP_TILT][LBC_TILT_MSB:0];
    assign expander_amount          = act[LBC_IDX_EXP_TILT][LBC_AMOUNT_MSB:LBC_AMOUNT_LSB];
    assign expander_threshold       = act[LBC_IDX_EXP_THR];
    assign window_length_select     = act[LBC_IDX_EXP_WIN][LBC_WL_BIT];
    assign half_start_line          = act[LBC_IDX_EXP_WIN][LBC_HSTART_MSB:LBC_HSTART_LSB];
    assign expander_disable_mask    = act[LBC_IDX_EXP_DIS][LBC_MASK_MSB:0];
    assign undershoot_level         = act[LBC_IDX_PK_GAIN][LBC_UNDER_MSB:0];
    assign overshoot_level          = act[LBC_IDX_PK_GAIN][LBC_OVER_MSB:LBC_OVER_LSB];
    assign peaking_invert           = act[LBC_IDX_PK_GAIN][LBC_INVERT_BIT];
    assign coring_level             = act[LBC_IDX_PK_CORING][LBC_CORING_MSB:0];
    assign center_frequency_select  = act[LBC_IDX_PK_CORING][LBC_FREQ_BIT];
    assign transient_suppress_mask  = act[LBC_IDX_TRANS][LBC_MASK_MSB:0];

    // Per-priority selection
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            use_side_set              <= 1'b0;
            use_external_rgb          <= 1'b0;
            expander_active           <= 1'b0;
            transient_suppress_active <= 1'b0;
            contrast_gain             <= 6'h00;
            brightness_offset         <= 9'h000;
        end else begin
            use_side_set              <= picture_set_select_mask[signal_priority];
            use_external_rgb          <= external_rgb_select_mask[signal_priority];
            expander_active           <= !expander_disable_mask[signal_priority]
                                         && expander_threshold != 9'h000;
            transient_suppress_active <= transient_suppress_mask[signal_priority];
            contrast_gain             <= picture_set_select_mask[signal_priority]
                                         ? side_contrast_gain : main_contrast_gain;
            brightness_offset         <= picture_set_select_mask[signal_priority]
                                         ? side_brightness_offset
                                         : main_brightness_offset;
        end
    end

    // Derived window and peaking values
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            window_start_line    <= 9'h000;
            window_stop_line     <= 9'h000;
            peaking_gain_eighths <= 6'h00;
        end else begin
            window_start_line <= {half_start_line, 1'b0};
            if (window_length_select) begin
                window_stop_line <= (LBC_STOP_60HZ > {half_start_line, 1'b0})
                    ? 9'(LBC_STOP_60HZ - {half_start_line, 1'b0}) : 9'h000;
            end else begin
                window_stop_line <= (LBC_STOP_50HZ > {half_start_line, 1'b0})
                    ? 9'(LBC_STOP_50HZ - {half_start_line, 1'b0}) : 9'h000;
            end
            peaking_gain_eighths <= LBC_PK_UNITY + 6'(undershoot_level)
                                    + 6'(overshoot_level);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    AST_VSYNC_ONLY: assert property (
        $changed(main_brightness_offset) |-> $past(vs_edge))
        else $error("Brightness changed outside vertical sync");
    AST_CONTRAST_LATCH: assert property (
        vs_edge |=> main_contrast_gain == $past(shadow[LBC_IDX_MAIN_CONT][5:0]))
        else $error("Main contrast not latched at vertical sync");
    AST_SIDE_SELECT: assert property (
        !srst |=> use_side_set == $past(picture_set_select_mask[signal_priority]))
        else $error("Side set select wrong for priority");
    AST_EXT_RGB: assert property (
        !srst |=> use_external_rgb == $past(external_rgb_select_mask[signal_priority]))
        else $error("External RGB select wrong for priority");
    AST_EXPANDER: assert property (
        (expander_threshold == 9'h000 && $stable(expander_threshold)) |=> !expander_active)
        else $error("Expander active with zero threshold");
    AST_BRIGHT_SEL: assert property (
        !srst |=> brightness_offset == ($past(picture_set_select_mask[signal_priority])
            ? $past(side_brightness_offset) : $past(main_brightness_offset)))
        else $error("Brightness source wrong");
    AST_PK_GAIN: assert property (
        !srst |=> peaking_gain_eighths
            == 6'($past(undershoot_level)) + 6'($past(overshoot_level)) + 6'h08)
        else $error("Peaking gain wrong");
    AST_STOP_LINE: assert property (
        !srst && $stable(act[LBC_IDX_EXP_WIN]) && !window_length_select
        && half_start_line < 8'ha8
        |=> window_stop_line == 9'(9'h150 - {$past(half_start_line), 1'b0}))
        else $error("Window stop line wrong");
    AST_ACK_LEN: assert property (
        $fell(sda_oe_n) |-> state == LBC_ST_ACK ##1 (state == LBC_ST_ACK) [*1])
        else $error("Acknowledge not held");
    AST_SIDE_LATCH: assert property (
        vs_edge |=> side_contrast_gain == $past(shadow[LBC_IDX_SIDE_CONT][5:0]))
        else $error("Side contrast not latched at vertical sync");
    AST_HOLD_FIELD: assert property (
        !vs_edge |=> $stable(expander_threshold) && $stable(transient_suppress_mask))
        else $error("Active field changed outside vertical sync");
    AST_TRANS_SEL: assert property (
        !srst |=> transient_suppress_active
            == $past(transient_suppress_mask[signal_priority]))
        else $error("Transient suppression select wrong for priority");
    AST_EXP_SEL: assert property (
        !srst |=> expander_active == (!$past(expander_disable_mask[signal_priority])
            && $past(expander_threshold) != 9'h000))
        else $error("Expander enable wrong for priority");
    AST_CONT_SEL: assert property (
        !srst |=> contrast_gain == ($past(picture_set_select_mask[signal_priority])
            ? $past(side_contrast_gain) : $past(main_contrast_gain)))
        else $error("Contrast source wrong");
    AST_START_LINE: assert property (
        !srst |=> window_start_line == {$past(half_start_line), 1'b0})
        else $error("Window start line wrong");
    AST_STOP_LINE_60: assert property (
        !srst && $stable(act[LBC_IDX_EXP_WIN]) && window_length_select
        && half_start_line < 8'h8e
        |=> window_stop_line == 9'(LBC_STOP_60HZ - {$past(half_start_line), 1'b0}))
        else $error("Window stop line wrong at 60 Hz");
    AST_REFUSED_SILENT: assert property (
        state == LBC_ST_SKIP |-> sda_oe_n)
        else $error("Acknowledge driven for refused telegram");
    AST_IDLE_RELEASED: assert property (
        state == LBC_ST_IDLE |-> sda_oe_n)
        else $error("Data line held in idle");
    AST_COMMIT_AFTER_LO: assert property (
        wr_commit |-> $past(state) == LBC_ST_LO)
        else $error("Register committed outside low byte");
    AST_SHADOW_WRITE: assert property (
        wr_commit && sub_addr == LBC_SUB_EXP_THR
        |=> shadow[LBC_IDX_EXP_THR] == $past(wr_data))
        else $error("Threshold shadow not written");
    AST_RESET_CLEAR: assert property (
        disable iff (1'b0) srst |=> main_brightness_offset == 9'h000
            && expander_threshold == 9'h000 && transient_suppress_mask == 8'h00 && sda_oe_n)
        else $error("Register not cleared by reset");
endmodule
`default_nettype wire

/* File: tb/lbc_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lbc_ctrl_model (
    // Clock
    input  wire logic clk_sys,
    // Bus lines
    output logic      scl,
    output logic      sda_drv,
    input  wire logic sda_line,
    // Outcome of last telegram
    output logic      nack_seen
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
        nack_seen = 1'b0;
    end

    task automatic hold_phase();
        repeat (6) @(posedge clk_sys);
    endtask

    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= -1; i--) begin
            sda_drv <= (i < 0) ? 1'b1 : b[i];
            hold_phase();
            scl <= 1'b1;
            hold_phase();
            if (i < 0 && sda_line !== 1'b0) begin
                nack_seen <= 1'b1;
            end
            scl <= 1'b0;
            hold_phase();
        end
    endtask

    // Start, address, subaddress, high byte, low byte, stop
    task automatic write_reg(input logic [6:0] addr, input logic [7:0] sub,
                             input logic [8:0] value);
        nack_seen <= 1'b0;
        sda_drv <= 1'b0;
        hold_phase();
        scl <= 1'b0;
        hold_phase();
        send_byte({addr, 1'b0});
        send_byte(sub);
        send_byte({7'h00, value[8]});
        send_byte(value[7:0]);
        sda_drv <= 1'b0;
        hold_phase();
        scl <= 1'b1;
        hold_phase();
        sda_drv <= 1'b1;
        hold_phase();
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_luma_backend_control_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_luma_backend_control_regs;
    import lbc_pkg::*;
    logic       clk_sys, srst, vsync, scl, sda_drv, nack_seen, sda_out, sda_oe_n;
    logic [2:0] signal_priority;
    logic [5:0] main_contrast_gain, side_contrast_gain, contrast_gain, peaking_gain_eighths;
    logic [8:0] main_brightness_offset, side_brightness_offset, brightness_offset;
    logic [8:0] expander_threshold, window_start_line, window_stop_line;
    logic [7:0] picture_set_select_mask, external_rgb_select_mask, half_start_line;
    logic [7:0] expander_disable_mask, transient_suppress_mask;
    logic [3:0] expander_tilt, undershoot_level, overshoot_level;
    logic [4:0] expander_amount, coring_level;
    logic       window_length_select, peaking_invert, center_frequency_select;
    logic       use_side_set, use_external_rgb, expander_active, transient_suppress_active;
    wire        sda_line = sda_drv & (sda_oe_n ? 1'b1 : sda_out);
    int         failures = 0;
    int         samples_checked = 0;
    localparam logic [7:0] SUBS [14] = '{8'h61, 8'h65, 8'h51, 8'h55, 8'h75, 8'h71, 8'h59,
        8'h5d, 8'h73, 8'h7d, 8'h69, 8'h6d, 8'h79, 8'h52};
    localparam logic [8:0] VALS [14] = '{9'h1a0, 9'h03f, 9'h100, 9'h0ff, 9'h0a5, 9'h05a,
        9'h1f7, 9'h0c8, 9'h01f, 9'h0f0, 9'h1f4, 9'h1e3, 9'h0c3, 9'h1ff};

    lbc_regs dut (.clk_sys, .srst, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe_n,
        .vsync, .signal_priority, .main_contrast_gain, .side_contrast_gain,
        .main_brightness_offset, .side_brightness_offset, .picture_set_select_mask,
        .external_rgb_select_mask, .expander_tilt, .expander_amount, .expander_threshold,
        .window_length_select, .half_start_line, .expander_disable_mask, .undershoot_level,
        .overshoot_level, .peaking_invert, .coring_level, .center_frequency_select,
        .transient_suppress_mask, .contrast_gain, .brightness_offset, .use_side_set,
        .use_external_rgb, .expander_active, .transient_suppress_active,
        .window_start_line, .window_stop_line, .peaking_gain_eighths);
    lbc_ctrl_model ctrl (.clk_sys, .scl, .sda_drv, .sda_line, .nack_seen);

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("Checked %0d values, %0d mismatches", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic pulse_vsync();
        @(posedge clk_sys);
        vsync <= 1'b1;
        @(posedge clk_sys);
        vsync <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic t_reset();
        check(main_contrast_gain, 9'h000);
        check(picture_set_select_mask, 9'h000);
        check(expander_threshold, 9'h000);
        check(sda_oe_n, 9'h001);
        check(sda_out, 9'h000);
    endtask

    // Reset in mid-run clears every written register
    task automatic t_mid_reset();
        srst <= 1'b1;
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check(main_brightness_offset, 9'h000);
        check(side_contrast_gain, 9'h000);
        check(expander_disable_mask, 9'h000);
        check(window_stop_line, 9'd336);
        check(peaking_gain_eighths, 9'd8);
        check(sda_oe_n, 9'h001);
    endtask

    // Full table written, fields held until vsync, then split into fields
    task automatic t_write_latch();
        for (int i = 0; i < 14; i++) begin
            ctrl.write_reg(LBC_CHIP_ADDR, SUBS[i], VALS[i]);
            check(nack_seen, 9'h000);
        end
        repeat (8) @(posedge clk_sys);
        check(main_contrast_gain, 9'h000);
        check(transient_suppress_mask, 9'h000);
        pulse_vsync();
        check(main_contrast_gain, 9'h020);
        check(side_contrast_gain, 9'h03f);
        check(main_brightness_offset, 9'h100);
        check(side_brightness_offset, 9'h0ff);
        check(picture_set_select_mask, 9'h0a5);
        check(external_rgb_select_mask, 9'h05a);
        check(expander_tilt, 9'h007);
        check(expander_amount, 9'h01f);
        check(expander_threshold, 9'h0c8);
        check(window_length_select, 9'h001);
        check(half_start_line, 9'h00f);
        check(window_start_line, 9'd30);
        check(window_stop_line, 9'd253);
        check(expander_disable_mask, 9'h0f0);
        check(undershoot_level, 9'h004);
        check(overshoot_level, 9'h00f);
        check(peaking_gain_eighths, 9'd27);
        check(peaking_invert, 9'h001);
        check(coring_level, 9'h003);
        check(center_frequency_select, 9'h001);
        check(transient_suppress_mask, 9'h0c3);
    endtask

    // Every priority picks its own mask bits
    task automatic t_priority();
        for (int p = 0; p < 8; p++) begin
            signal_priority <= p[2:0];
            repeat (4) @(posedge clk_sys);
            check(use_side_set, VALS[4][p]);
            check(use_external_rgb, VALS[5][p]);
            check(expander_active, !VALS[9][p]);
            check(transient_suppress_active, VALS[12][p]);
            check(contrast_gain, VALS[4][p] ? 9'h03f : 9'h020);
            check(brightness_offset, VALS[4][p] ? 9'h0ff : 9'h100);
        end
    endtask

    // Zero threshold, 50 Hz window, and a refused telegram
    task automatic t_thr_win_refuse();
        signal_priority <= 3'h0;
        ctrl.write_reg(LBC_CHIP_ADDR, LBC_SUB_EXP_THR, 9'h000);
        ctrl.write_reg(LBC_CHIP_ADDR, LBC_SUB_EXP_WIN, 9'h014);
        ctrl.write_reg(7'h44, LBC_SUB_MAIN_CONT, 9'h000);
        check(nack_seen, 9'h001);
        pulse_vsync();
        check(expander_active, 9'h000);
        check(window_start_line, 9'd20);
        check(window_stop_line, 9'd316);
        check(main_contrast_gain, 9'h020);
    endtask

    initial begin
        repeat (60000) @(posedge clk_sys);
        $display("Error at %0t: watchdog expired", $time);
        failures++;
        test_done();
    end

    initial begin
        srst = 1'b1;
        vsync = 1'b0;
        signal_priority = 3'h0;
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        t_reset();
        t_write_latch();
        t_priority();
        t_thr_win_refuse();
        t_mid_reset();
        test_done();
    end
endmodule
`default_nettype wire
